/* src/eeprom_slave_map.vh */
// Constants for the two-wire EEPROM slave front end
`ifndef EEPROM_SLAVE_MAP_VH
`define EEPROM_SLAVE_MAP_VH
`define DEV_TYPE_ID        4'h5 // Device type code; value is arbitrary
`define DEV_TYPE_MSB       7
`define DEV_TYPE_LSB       4
`define STRAP_MSB          3
`define STRAP_LSB          1
`define RW_BIT             0
`define ADDR_RESET         16'h0000
`define PAGE_BITS          6
`define CLK_FREQ_HZ        50000000
`define PROG_TIME_US       5000
`define PROG_CYCLES        ((`PROG_TIME_US) * ((`CLK_FREQ_HZ) / 1000000))
`define BIT_CNT_W          4
`define ACK_SLOT           4'h8
`endif

/* src/pin_sync.v */
// Two-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // Clock and reset
    input  wire i_clk,
    input  wire i_rst,
    // Asynchronous pin in, synchronised level out
    input  wire i_pin,
    output reg  o_level
);
    reg meta; // First stage, read only by o_level

    // Two stages; reset value high matches an idle pulled-up line
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta    <= 1'b1;
            o_level <= 1'b1;
        end else begin
            meta    <= i_pin;
            o_level <= meta;
        end
    end
endmodule // pin_sync
`default_nettype wire

/* src/eeprom_slave.v */
// Two-wire serial EEPROM slave front end with byte and page write
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_slave_map.vh"
// How it works
// - Start is data falling while clock high
// - Watch for start except during programming
// - Stop is data rising while clock high
// - Stop after read no-ack returns to standby
// - Receiver pulls data low in ninth slot
// - Sample data on clock rising edge
// - Upper four select bits match type code
// - Bits b3..b1 match the three straps
// - Select bit zero: one read, zero write
// - Match acknowledges; mismatch releases, goes standby
// - Write protect high blocks array changes
// - Protected: ack select and address, nack data
// - Protect sampled from start to address end
// - Write select then two acknowledged address bytes
// - Address high byte first, then low byte
// - Program only on stop in tenth slot
// - After programming, counter points past last byte
// - Busy: data released, no response at all
// - Byte write: store if unprotected, else nack
// - Reset holds standby, ignores all instructions
// - Sequential read follows current or random read
// - Page write increments low six address bits
// - Random read: dummy write, restart, read select
// - Read counter increments and wraps to zero
// - Read no-ack ends transfer, enters standby
module eeprom_slave #(
    parameter PROG_CYCLES = `PROG_CYCLES // Programming time in clocks
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // Serial bus pins
    input  wire        i_scl,
    input  wire        i_sda,
    output reg         o_sda,
    output reg         o_sda_oe_n,
    // Straps and protection
    input  wire        i_strap_select_bit0,
    input  wire        i_strap_select_bit1,
    input  wire        i_strap_select_bit2,
    input  wire        i_write_protect_in,
    // Memory array port
    output reg  [15:0] o_mem_addr,
    output reg  [7:0]  o_mem_wdata,
    output reg         o_mem_we,
    input  wire [7:0]  i_mem_rdata,
    // Status
    output reg         o_busy
);
    // States, one-hot
    localparam [5:0] ST_IDLE = 6'h01; // Standby, waiting for start
    localparam [5:0] ST_DSEL = 6'h02; // Receiving select byte
    localparam [5:0] ST_ADRH = 6'h04; // Receiving high address
    localparam [5:0] ST_ADRL = 6'h08; // Receiving low address
    localparam [5:0] ST_WDAT = 6'h10; // Receiving write data
    localparam [5:0] ST_RDAT = 6'h20; // Transmitting read data
    localparam [7:0] PAGE_LEN = 8'h40; // Latch depth, one row

    // Synchronised pins
    wire scl_s;                    // Clock line level
    wire sda_s;                    // Data line level
    wire wp_s;                     // Write protect level
    wire [2:0] strap_s;            // Strap levels
    reg  scl_d;                    // Previous clock level
    reg  sda_d;                    // Previous data level

    // Protocol state
    reg  [5:0]  state;             // Current phase
    reg  [3:0]  bit_cnt;           // Bit slot 0..8
    reg  [7:0]  shift;             // Receive / transmit shift
    reg         ack_phase;         // In ninth slot
    reg         ack_drive;         // Cleared in reset, otherwise unused; o_sda_oe_n drives the ack
    reg         tenth;             // Slot just after the ninth slot of a low-address or data byte
    reg         protect;           // Protect seen in this write
    reg  [15:0] addr_cnt;          // Internal address counter
    reg  [15:0] base_addr;         // Row base for page write
    reg  [7:0]  page [0:63];       // Page latch, one row
    reg  [63:0] page_valid;        // Latched byte flags
    reg  [6:0]  nbytes;            // Bytes latched
    reg         prog;              // Programming in progress
    reg  [31:0] prog_cnt;          // Programming timer
    reg  [5:0]  flush_idx;         // Array copy index
    reg         flushing;          // Copying latch to array

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

    // Two-flop synchronisers; straps float low at the pin per board pulls
    pin_sync u_scl (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_scl), .o_level(scl_s));
    pin_sync u_sda (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_sda), .o_level(sda_s));
    pin_sync u_wp  (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_write_protect_in),
                    .o_level(wp_s));
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_strap
            wire raw;
            assign raw = (g == 0) ? i_strap_select_bit0 :
                         (g == 1) ? i_strap_select_bit1 : i_strap_select_bit2;
            pin_sync u_s (.i_clk(i_clk), .i_rst(i_rst), .i_pin(raw),
                          .o_level(strap_s[g]));
        end
    endgenerate

    // Select byte decode on the received shift value
    wire sel_match = (shift[`DEV_TYPE_MSB:`DEV_TYPE_LSB] == `DEV_TYPE_ID)
                   & (shift[`STRAP_MSB:`STRAP_LSB] == strap_s);

    // Edge history
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Programming timer and latch flush; bus is deaf meanwhile
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prog_cnt  <= 32'h0;
            flush_idx <= 6'h0;
            flushing  <= 1'b0;
            o_mem_we  <= 1'b0;
            o_mem_wdata <= 8'h00;
            o_busy    <= 1'b0;
        end else begin
            o_mem_we <= 1'b0;
            if (stop_ev && tenth && !protect && nbytes != 7'h0 && !prog) begin
                prog_cnt  <= PROG_CYCLES - 1;
                flushing  <= 1'b1;
                flush_idx <= 6'h0;
                o_busy    <= 1'b1;
            end else if (prog) begin
                if (flushing) begin
                    // One latched byte per clock, only those written
                    o_mem_we    <= page_valid[flush_idx];
                    o_mem_wdata <= page[flush_idx];
                    flush_idx   <= flush_idx + 6'h1;
                    if (flush_idx == 6'h3F)
                        flushing <= 1'b0;
                end
                if (prog_cnt != 32'h0)
                    prog_cnt <= prog_cnt - 32'h1;
                else
                    o_busy <= 1'b0;
            end
        end
    end

    // Main protocol engine
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state      <= ST_IDLE;
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            ack_phase  <= 1'b0;
            ack_drive  <= 1'b0;
            tenth      <= 1'b0;
            protect    <= 1'b0;
            addr_cnt   <= `ADDR_RESET;
            base_addr  <= `ADDR_RESET;
            page_valid <= 64'h0;
            nbytes     <= 7'h0;
            prog       <= 1'b0;
            o_sda      <= 1'b0;
            o_sda_oe_n <= 1'b1;
            o_mem_addr <= `ADDR_RESET;
        end else if (prog) begin
            // Deaf and released until the timer runs out
            o_sda_oe_n <= 1'b1;
            state      <= ST_IDLE;
            tenth      <= 1'b0;
            o_mem_addr <= {base_addr[15:`PAGE_BITS], flush_idx};
            if (!o_busy && !flushing) begin
                prog       <= 1'b0;
                page_valid <= 64'h0;
                nbytes     <= 7'h0;
            end
        end else if (stop_ev) begin
            if (tenth && !protect && nbytes != 7'h0) begin
                prog <= 1'b1;
                // Counter already stands after the last latched byte
            end else begin
                page_valid <= 64'h0;
                nbytes     <= 7'h0;
            end
            state      <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
            tenth      <= 1'b0;
        end else if (start_ev) begin
            state      <= ST_DSEL;
            bit_cnt    <= 4'h0;
            ack_phase  <= 1'b0;
            tenth      <= 1'b0;
            protect    <= wp_s;
            page_valid <= 64'h0;
            nbytes     <= 7'h0;
            o_sda_oe_n <= 1'b1;
        end else if (state != ST_IDLE) begin
            if ((state == ST_ADRH || state == ST_ADRL || state == ST_DSEL) && wp_s)
                protect <= 1'b1;
            if (scl_rise) begin
                if (ack_phase) begin
                    // Ninth slot: for reads the master answers here
                    if (state == ST_RDAT && sda_s) begin
                        state <= ST_IDLE;
                    end else if (state == ST_RDAT) begin
                        // Point the array at this byte, step the counter past it
                        o_mem_addr <= addr_cnt;
                        addr_cnt   <= addr_cnt + 16'h1;
                    end
                end else if (state == ST_RDAT) begin
                    // Our own bit is on the line; only count the slot
                    bit_cnt <= bit_cnt + 4'h1;
                end else begin
                    shift   <= {shift[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                // Tenth slot lasts until the clock falls again
                tenth <= 1'b0;
                if (ack_phase) begin
                    // Leave the ninth slot
                    ack_phase <= 1'b0;
                    bit_cnt   <= 4'h0;
                    tenth     <= (state == ST_WDAT);
                    if (state == ST_RDAT) begin
                        shift      <= i_mem_rdata;
                        o_sda      <= 1'b0;
                        o_sda_oe_n <= i_mem_rdata[7];
                    end else begin
                        o_sda_oe_n <= 1'b1;
                    end
                end else if (bit_cnt == `ACK_SLOT) begin
                    ack_phase <= 1'b1;
                    o_sda     <= 1'b0;
                    case (state)
                        ST_DSEL: begin
                            if (sel_match) begin
                                o_sda_oe_n <= 1'b0;
                                if (shift[`RW_BIT]) begin
                                    state      <= ST_RDAT;
                                    o_mem_addr <= addr_cnt;
                                end else begin
                                    state <= ST_ADRH;
                                end
                            end else begin
                                o_sda_oe_n <= 1'b1;
                                state      <= ST_IDLE;
                            end
                        end
                        ST_ADRH: begin
                            addr_cnt[15:8] <= shift;
                            o_sda_oe_n     <= 1'b0;
                            state          <= ST_ADRL;
                        end
                        ST_ADRL: begin
                            addr_cnt[7:0] <= shift;
                            base_addr     <= {addr_cnt[15:8], shift};
                            o_sda_oe_n    <= 1'b0;
                            state         <= ST_WDAT;
                        end
                        ST_WDAT: begin
                            if (protect) begin
                                o_sda_oe_n <= 1'b1;
                            end else begin
                                o_sda_oe_n <= 1'b0;
                                page[addr_cnt[`PAGE_BITS-1:0]] <= shift;
                                page_valid[addr_cnt[`PAGE_BITS-1:0]] <= 1'b1;
                                if (nbytes != PAGE_LEN[6:0])
                                    nbytes <= nbytes + 7'h1;
                                addr_cnt[`PAGE_BITS-1:0] <=
                                    addr_cnt[`PAGE_BITS-1:0] + 6'h1;
                            end
                        end
                        ST_RDAT: begin
                            o_sda_oe_n <= 1'b1;
                        end
                        default: begin
                            state      <= ST_IDLE;
                            o_sda_oe_n <= 1'b1;
                        end
                    endcase
                end else if (state == ST_RDAT) begin
                    // Shift next read bit; release for ones
                    o_sda_oe_n <= shift[6];
                    shift      <= {shift[6:0], 1'b0};
                end
            end
        end else begin
            o_sda_oe_n <= 1'b1;
        end
    end
endmodule // eeprom_slave
`default_nettype wire

/* testbench/eeprom_slave_assertions.sv */
// Concurrent port checks for the two-wire EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave_assertions #(
    parameter int PROG_CYCLES = 200 // Programming time in clocks
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Bus pins and status
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe_n,
    input wire logic o_mem_we,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [31:0] busy_len; // Cycles busy so far
    // Length of the running busy stretch; a counter avoids long repetitions
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) busy_len <= 32'h0;
        else busy_len <= o_busy ? busy_len + 32'h1 : 32'h0;
    end
    chk_busy_silent: assert property (o_busy |-> o_sda_oe_n)
        else $error("data line driven while busy");
    chk_drive_zero: assert property (!o_sda_oe_n |-> o_sda == 1'b0)
        else $error("data line driven high");
    chk_we_in_busy: assert property (o_mem_we |-> o_busy)
        else $error("array write outside programming");
    chk_edge_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
        else $error("data drive changed while clock high");
    chk_ack_holds: assert property ($fell(o_sda_oe_n) |=> !o_sda_oe_n [*8])
        else $error("data drive too short");
    chk_prog_len: assert property ($fell(o_busy) |->
        busy_len >= PROG_CYCLES - 1 && busy_len <= PROG_CYCLES + 2)
        else $error("programming time wrong");
    chk_prog_on_stop: assert property ($rose(o_busy) |-> i_scl && i_sda)
        else $error("programming began without stop");
    chk_reset_quiet: assert property (disable iff (1'b0)
        i_rst |-> o_sda_oe_n && !o_busy && !o_mem_we)
        else $error("outputs active in reset");
    cov_busy: cover property ($rose(o_busy));
    cov_ack: cover property ($fell(o_sda_oe_n));
    cov_write: cover property (o_mem_we);
endmodule // eeprom_slave_assertions
bind eeprom_slave eeprom_slave_assertions #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n), .o_mem_we(o_mem_we), .o_busy(o_busy));
`default_nettype wire

/* testbench/i2c_master_model.sv */
// Behavioural two-wire bus master for the EEPROM bench
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    // Clock and wired data line
    input  wire logic i_clk,
    input  wire logic i_sda,
    // Bus clock and data pull-down
    output logic      o_scl,
    output logic      o_sda_low
);
    // Idle bus: clock stands high, data released to the pull-up
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Eight clocks per phase so the synchroniser sees every change
    task gap;
        repeat (8) @(posedge i_clk);
    endtask
    // Start or repeated start: data falls while clock high
    task start;
        o_sda_low <= 1'b0;
        gap;
        o_scl <= 1'b1;
        gap;
        o_sda_low <= 1'b1;
        gap;
        o_scl <= 1'b0;
        gap;
    endtask
    // Stop: data rises while clock high
    task stop;
        o_sda_low <= 1'b1;
        gap;
        o_scl <= 1'b1;
        gap;
        o_sda_low <= 1'b0;
        gap;
    endtask
    // One bit; data changes only with clock low, sampled mid-high
    task bit_slot(input logic v, output logic s);
        o_sda_low <= ~v;
        gap;
        o_scl <= 1'b1;
        repeat (4) @(posedge i_clk);
        s = i_sda;
        repeat (4) @(posedge i_clk);
        o_scl <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    // Byte out MSB first, released ninth slot returns the answer
    task send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
        bit_slot(1'b1, s);
        ack = ~s;
    endtask
    // Byte in, then master acknowledge or not in ninth slot
    task recv(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, s);
            b[i] = s;
        end
        bit_slot(~ack_it, s);
    endtask
endmodule // i2c_master_model
`default_nettype wire

/* testbench/eeprom_slave_tb_top.sv */
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_slave_map.vh"
module eeprom_slave_tb_top;
    localparam int PROG = 600;       // Shortened programming time
    logic        i_clk = 1'b0;       // System clock
    logic        i_rst = 1'b0;       // Reset, raised by an edge at time zero
    logic [2:0]  strap = 3'h0;       // Strap levels
    logic        wp = 1'b0;          // Write protect level
    logic [7:0]  mem [0:65535];      // Array model
    wire         scl, m_low, oe_n, sda_o, we, busy;
    wire  [15:0] maddr;              // Array address
    wire  [7:0]  wdata;              // Array write data
    wire  [7:0]  rdata = mem[maddr]; // Combinational array read
    wire         sda = ~(m_low | (~oe_n & ~sda_o)); // Pulled-up wired line
    integer      n_fail = 0, checks = 0, seed = 84, cyc = 0, w;
    logic        ack;
    logic [7:0]  rd, d;
    logic [15:0] a, b;
    logic [31:0] r;
    always #10 i_clk = ~i_clk;
    // Array model takes the design's write strobe
    always @(posedge i_clk) if (we) mem[maddr] <= wdata;
    i2c_master_model m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
    eeprom_slave #(.PROG_CYCLES(PROG)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda(sda_o),
        .o_sda_oe_n(oe_n), .i_strap_select_bit0(strap[0]), .i_strap_select_bit1(strap[1]),
        .i_strap_select_bit2(strap[2]), .i_write_protect_in(wp), .o_mem_addr(maddr),
        .o_mem_wdata(wdata), .o_mem_we(we), .i_mem_rdata(rdata), .o_busy(busy));
    // Compare with case inequality so unknowns fail
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Expected select byte from type code and straps
    function logic [7:0] selb(input logic rw);
        return {`DEV_TYPE_ID, strap, rw};
    endfunction
    // Select and both address bytes, optional protect pulse mid-address
    task hdr(input logic [15:0] ad, input logic pw);
        m.start;
        m.send(selb(1'b0), ack);
        cmp(ack, 1'b1);
        wp <= pw;
        m.send(ad[15:8], ack);
        cmp(ack, 1'b1);
        wp <= 1'b0;
        m.send(ad[7:0], ack);
        cmp(ack, 1'b1);
    endtask
    // Bounded wait for programming to end
    task wait_idle;
        w = 0;
        while (busy !== 1'b0 && w < 2000) begin
            @(posedge i_clk);
            w++;
        end
        cmp(busy, 1'b0);
    endtask
    // Byte write; protected data must be refused and not programmed
    task wr_byte(input logic [15:0] ad, input logic [7:0] dv, input logic pw);
        hdr(ad, pw);
        m.send(dv, ack);
        cmp(ack, {7'h00, ~pw});
        m.stop;
        m.gap;
        cmp(busy, {7'h00, ~pw});
        wait_idle;
    endtask
    // Random read: dummy write, repeated start, read select, no-ack
    task rd_at(input logic [15:0] ad, output logic [7:0] v);
        hdr(ad, 1'b0);
        m.start;
        m.send(selb(1'b1), ack);
        cmp(ack, 1'b1);
        m.recv(1'b0, v);
        m.stop;
    endtask
    task complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard well above the expected run length
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            complete_run;
        end
    end
    initial begin
        i_rst <= 1'b1; // Edge at time zero fires the asynchronous reset
        for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
        repeat (5) @(posedge i_clk);
        cmp(oe_n, 1'b1);
        cmp(busy, 1'b0);
        r = $random(seed);
        strap <= r[2:0];
        i_rst <= 1'b0;
        repeat (5) @(posedge i_clk);
        // Each wrong bit of type code or straps must be ignored
        for (int i = 1; i < 8; i++) begin
            m.start;
            m.send(selb(1'b0) ^ (8'h01 << i), ack);
            cmp(ack, 1'b0);
            m.stop;
        end
        $display("test select done");
        // Random writes with readback; poll while busy must be ignored
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            a = r[15:0] & 16'hFFFE; // Even, so a+1 stays in the same row
            d = r[23:16];
            hdr(a + 16'h0001, 1'b0);
            m.send(~d, ack);
            m.stop;
            m.start;
            m.send(selb(1'b0), ack);
            cmp(ack, 1'b0);
            m.stop;
            wait_idle;
            wr_byte(a, d, 1'b0);
            m.start;
            m.send(selb(1'b1), ack);
            cmp(ack, 1'b1);
            m.recv(1'b0, rd);
            m.stop;
            cmp(rd, ~d);
            rd_at(a, rd);
            cmp(rd, d);
        end
        $display("test write done");
        // Protect pulse during address, then stop with no data byte
        wr_byte(a, ~d, 1'b1);
        rd_at(a, rd);
        cmp(rd, d);
        hdr(a, 1'b0);
        m.stop;
        m.gap;
        cmp(busy, 1'b0);
        $display("test protect done");
        // Page write across row end wraps inside the row
        b = {a[15:6], 6'h3F};
        hdr(b, 1'b0);
        m.send(d, ack);
        m.send(~d, ack);
        cmp(ack, 1'b1);
        m.send(d ^ 8'h5A, ack);
        cmp(ack, 1'b1);
        m.stop;
        m.gap;
        wait_idle;
        rd_at({a[15:6], 6'h00}, rd);
        cmp(rd, ~d);
        rd_at(b, rd);
        cmp(rd, d);
        // Sequential read: master acks the first byte and takes the next
        hdr({a[15:6], 6'h00}, 1'b0);
        m.start;
        m.send(selb(1'b1), ack);
        cmp(ack, 1'b1);
        m.recv(1'b1, rd);
        cmp(rd, ~d);
        m.recv(1'b0, rd);
        cmp(rd, d ^ 8'h5A);
        m.stop;
        $display("test page done");
        complete_run;
    end
endmodule // eeprom_slave_tb_top
`default_nettype wire
